// ===== ccsp_pkg.sv
// constants, types and field layout for the collection segment parser
package ccsp_pkg;

  // ****************************************
  // markers and length field
  // ****************************************
  localparam logic [7:0] MARKER_PREFIX = 8'hff;
  localparam logic [7:0] CODE_DECORR = 8'h75;
  localparam logic [7:0] CODE_DEPEND = 8'h78;
  localparam logic [1:0] LEN_LAST_BYTE = 2'h3;
  localparam logic [31:0] LEN_FIELD_BYTES = 32'h0000_0004;
  localparam logic [31:0] LEN_MIN = 32'h0000_0005;
  localparam logic [8:0] MAIN_SEG_MAX = 9'h100;

  // ****************************************
  // field positions
  // ****************************************
  localparam int XF_MATRIX_BIT = 1;
  localparam int CNT_SEL_HI = 15;
  localparam int CNT_SEL_LO = 14;
  localparam int CNT_MSB = 13;
  localparam int NIB_LO_MSB = 3;
  localparam int NIB_HI_LSB = 4;
  localparam logic [1:0] SEL_NARROW = 2'h0;
  localparam logic [1:0] SEL_WIDE = 2'h1;
  localparam logic KIND_DECORR = 1'b0;
  localparam logic KIND_DEPEND = 1'b1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    XT_MATRIX = 2'b00,
    XT_WAVE_LOW = 2'b10,
    XT_WAVE_HIGH = 2'b11
  } ccsp_xform_t;

  typedef enum logic [2:0] {
    ERR_NONE = 3'b000,
    ERR_LENGTH = 3'b001,
    ERR_RESERVED = 3'b010,
    ERR_SQUARE = 3'b011,
    ERR_DUP = 3'b100,
    ERR_TILE_DUP = 3'b101,
    ERR_NOT_FIRST = 3'b110,
    ERR_MAIN_FULL = 3'b111
  } ccsp_err_t;

  typedef enum logic [3:0] {
    ST_HUNT = 4'b0000,
    ST_MARK = 4'b0001,
    ST_LEN = 4'b0010,
    ST_SEGIDX = 4'b0011,
    ST_XFORM = 4'b0100,
    ST_NCNT_HI = 4'b0101,
    ST_NCNT_LO = 4'b0110,
    ST_NIDX = 4'b0111,
    ST_MCNT_HI = 4'b1000,
    ST_MCNT_LO = 4'b1001,
    ST_MIDX = 4'b1010,
    ST_ASSIGN = 4'b1011,
    ST_EMIT = 4'b1100,
    ST_DONE = 4'b1101,
    ST_DRAIN = 4'b1110
  } ccsp_state_t;

endpackage

// ===== ccsp_seen_map.sv
// one-bit-per-index memory that reports repeated component indices
`timescale 1ns/1ps
`default_nettype none
module ccsp_seen_map #(
  parameter int DEPTH = 16384,
  parameter int AW = 14
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clear_start,
  output logic busy,
  input wire logic check_valid,
  input wire logic [AW-1:0] check_index,
  output logic dup
);

  // refuse a depth the sweep counter cannot cover
  if (DEPTH != (1 << AW)) begin : g_depth_check
    $error("ccsp_seen_map: DEPTH must be 2**AW");
  end

  logic seen [DEPTH];
  logic [AW-1:0] sweep;
  logic sweep_last;

  assign sweep_last = (sweep == {AW{1'b1}});
  assign dup = check_valid && seen[check_index];

  // sweep after reset and at the start of each segment body whose length is valid
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b1;
      sweep <= '0;
    end else if (clear_start) begin
      busy <= 1'b1;
      sweep <= '0;
    end else if (busy) begin
      busy <= !sweep_last;
      sweep <= sweep + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (busy) begin
      seen[sweep] <= 1'b0;
    end else if (check_valid) begin
      seen[check_index] <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== ccsp_parser.sv
// parser for decorrelation and dependency collection header segments
`timescale 1ns/1ps
`default_nettype none
module ccsp_parser
  import ccsp_pkg::*;
#(
  parameter int COMP_SPACE = 16384,
  parameter int COMP_AW = 14
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic IN_VALID,
  input wire logic [7:0] IN_DATA,
  output logic IN_READY,
  input wire logic IN_MAIN_HDR,
  input wire logic IN_FIRST_TILE_PART,
  input wire logic TILE_START,
  output logic IDX_VALID,
  input wire logic IDX_READY,
  output logic [15:0] IDX_DATA,
  output logic IDX_OUTPUT,
  output logic IDX_KIND,
  output logic DESC_VALID,
  input wire logic DESC_READY,
  output logic DESC_KIND,
  output logic [7:0] DESC_SEG_INDEX,
  output logic [1:0] DESC_XFORM,
  output logic [13:0] DESC_IN_COUNT,
  output logic DESC_IN_WIDE,
  output logic [13:0] DESC_OUT_COUNT,
  output logic DESC_OUT_WIDE,
  output logic [3:0] DESC_PRIMARY_INDEX,
  output logic DESC_PRIMARY_EN,
  output logic [3:0] DESC_SECONDARY_INDEX,
  output logic DESC_SECONDARY_EN,
  output logic DESC_TILE_FIRST,
  output logic SEG_DONE,
  output logic SEG_KIND,
  output logic [7:0] SEG_INDEX,
  output logic SEG_MAIN,
  output logic ERR_VALID,
  output logic [2:0] ERR_CODE,
  output logic [1:0] MAIN_DEFAULT,
  output logic [1:0] TILE_OWN,
  output logic [1:0] TILE_REF,
  output logic [7:0] REF_INDEX_DECORR,
  output logic [7:0] REF_INDEX_DEPEND
);

  // refuse an index space the seen map cannot serve
  if (COMP_AW != 14 || COMP_SPACE != (1 << COMP_AW)) begin : g_space_check
    $error("ccsp_parser: component index space must be 2**14");
  end

  // ****************************************
  // state
  // ****************************************
  ccsp_state_t state, next_state;
  ccsp_err_t next_err;
  logic kind;
  logic seg_main;
  logic [1:0] byte_cnt;
  logic [31:0] len;
  logic [31:0] rem;
  logic [7:0] hold;
  logic phase;
  logic [13:0] idx_left;
  logic [7:0] assign_byte;
  logic [8:0] main_cnt [2];
  logic map_busy;
  logic map_dup;

  // ****************************************
  // decode
  // ****************************************
  wire take = IN_VALID && IN_READY;
  wire in_body = (state == ST_SEGIDX) || (state == ST_XFORM) || (state == ST_NCNT_HI) ||
                 (state == ST_NCNT_LO) || (state == ST_NIDX) || (state == ST_MCNT_HI) ||
                 (state == ST_MCNT_LO) || (state == ST_MIDX) || (state == ST_ASSIGN);
  wire rem_zero = (rem == 32'h0000_0000);
  wire [31:0] rem_dec = rem - 32'h0000_0001;
  wire rem_after_zero = (rem_dec == 32'h0000_0000);
  wire [31:0] len_full = {len[23:0], IN_DATA};
  wire [15:0] cnt_word = {hold, IN_DATA};
  wire [1:0] cnt_sel = cnt_word[CNT_SEL_HI:CNT_SEL_LO];
  wire [13:0] cnt_val = cnt_word[CNT_MSB:0];
  wire cnt_bad = (cnt_sel != SEL_NARROW) && (cnt_sel != SEL_WIDE);
  wire cur_wide = (state == ST_NIDX) ? DESC_IN_WIDE : DESC_OUT_WIDE;
  wire idx_needs_hi = cur_wide && !phase;
  wire [15:0] idx_word = cur_wide ? {hold, IN_DATA} : {8'h00, IN_DATA};
  wire idx_bad = (idx_word[CNT_SEL_HI:CNT_SEL_LO] != 2'h0);
  wire idx_emit = take && ((state == ST_NIDX) || (state == ST_MIDX)) && !idx_needs_hi &&
                  !rem_zero;
  wire idx_last = (idx_left == 14'h0001);
  wire check_out = idx_emit && (state == ST_MIDX);
  wire out_mismatch = (cnt_val != DESC_IN_COUNT);
  wire square_bad = (kind == KIND_DEPEND) || DESC_XFORM[XF_MATRIX_BIT];
  wire main_full = (main_cnt[kind] == MAIN_SEG_MAX);
  wire tile_ctx_bad = !IN_FIRST_TILE_PART;
  wire tile_dup = TILE_OWN[kind] || TILE_REF[kind];
  wire seg_ref = !seg_main && (DESC_SEG_INDEX != 8'h00);
  wire start_body = take && (state == ST_LEN) && (byte_cnt == LEN_LAST_BYTE) &&
                    (len_full >= LEN_MIN);
  wire [1:0] kind_hot = (kind == KIND_DEPEND) ? 2'b10 : 2'b01;
  wire commit = (state == ST_DONE);

  // stall input while a descriptor or an index waits, or while the map clears
  assign IN_READY = (state != ST_EMIT) && (state != ST_DONE) && !map_busy &&
                    !(IDX_VALID && !IDX_READY);
  assign DESC_VALID = (state == ST_EMIT);
  assign DESC_PRIMARY_INDEX = assign_byte[NIB_LO_MSB:0];
  assign DESC_SECONDARY_INDEX = assign_byte[7:NIB_HI_LSB];
  assign DESC_PRIMARY_EN = (assign_byte[NIB_LO_MSB:0] != 4'h0);
  assign DESC_SECONDARY_EN = (assign_byte[7:NIB_HI_LSB] != 4'h0);
  assign DESC_TILE_FIRST = !seg_main;

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    next_err = ERR_NONE;
    if (state == ST_EMIT) begin
      if (DESC_READY) begin
        next_state = rem_zero ? ST_DONE :
                     (kind == KIND_DECORR) ? ST_XFORM : ST_NCNT_HI;
      end
    end else if (state == ST_DONE) begin
      next_state = ST_HUNT;
    end else if (take && in_body && rem_zero) begin
      next_err = ERR_LENGTH;
    end else if (take) begin
      unique case (state)
        ST_HUNT: begin
          if (IN_DATA == MARKER_PREFIX) begin
            next_state = ST_MARK;
          end
        end
        ST_MARK: begin
          if (IN_DATA == CODE_DECORR || IN_DATA == CODE_DEPEND) begin
            next_state = ST_LEN;
          end else if (IN_DATA != MARKER_PREFIX) begin
            next_state = ST_HUNT;
          end
        end
        ST_LEN: begin
          if (byte_cnt == LEN_LAST_BYTE) begin
            next_state = (len_full >= LEN_MIN) ? ST_SEGIDX : ST_HUNT;
            if (len_full < LEN_MIN) begin
              next_err = ERR_LENGTH;
            end
          end
        end
        ST_SEGIDX: begin
          if (seg_main && main_full) begin
            next_err = ERR_MAIN_FULL;
          end else if (!seg_main && tile_ctx_bad) begin
            next_err = ERR_NOT_FIRST;
          end else if (!seg_main && tile_dup) begin
            next_err = ERR_TILE_DUP;
          end else if (!seg_main && IN_DATA != 8'h00 && !rem_after_zero) begin
            next_err = ERR_LENGTH;
          end else if (rem_after_zero) begin
            next_state = ST_DONE;
          end else begin
            next_state = (kind == KIND_DECORR) ? ST_XFORM : ST_NCNT_HI;
          end
        end
        ST_XFORM: next_state = ST_NCNT_HI;
        ST_NCNT_HI: next_state = ST_NCNT_LO;
        ST_NCNT_LO: begin
          if (cnt_bad) begin
            next_err = ERR_RESERVED;
          end else begin
            next_state = (cnt_val == 14'h0000) ? ST_MCNT_HI : ST_NIDX;
          end
        end
        ST_NIDX: begin
          if (idx_emit && idx_bad) begin
            next_err = ERR_RESERVED;
          end else if (idx_emit && idx_last) begin
            next_state = ST_MCNT_HI;
          end
        end
        ST_MCNT_HI: next_state = ST_MCNT_LO;
        ST_MCNT_LO: begin
          if (cnt_bad) begin
            next_err = ERR_RESERVED;
          end else if (square_bad && out_mismatch) begin
            next_err = ERR_SQUARE;
          end else begin
            next_state = (cnt_val == 14'h0000) ? ST_ASSIGN : ST_MIDX;
          end
        end
        ST_MIDX: begin
          if (idx_emit && idx_bad) begin
            next_err = ERR_RESERVED;
          end else if (map_dup) begin
            next_err = ERR_DUP;
          end else if (idx_emit && idx_last) begin
            next_state = ST_ASSIGN;
          end
        end
        ST_ASSIGN: next_state = ST_EMIT;
        ST_DRAIN: begin
          if (rem_zero || rem_after_zero) begin
            next_state = ST_HUNT;
          end
        end
        default: next_state = ST_HUNT;
      endcase
    end
    // a failed segment is drained by its length, then hunting resumes
    if (next_err != ERR_NONE) begin
      next_state = (in_body && !rem_zero && !rem_after_zero) ? ST_DRAIN : ST_HUNT;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state <= ST_HUNT;
      ERR_VALID <= 1'b0;
      ERR_CODE <= ERR_NONE;
    end else begin
      state <= next_state;
      ERR_VALID <= (next_err != ERR_NONE);
      if (next_err != ERR_NONE) begin
        ERR_CODE <= next_err;
      end
    end
  end

  // ****************************************
  // header fields
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      kind <= KIND_DECORR;
      seg_main <= 1'b1;
      byte_cnt <= 2'h0;
      len <= 32'h0000_0000;
      rem <= 32'h0000_0000;
    end else if (take) begin
      if (state == ST_MARK) begin
        kind <= (IN_DATA == CODE_DEPEND) ? KIND_DEPEND : KIND_DECORR;
        seg_main <= IN_MAIN_HDR;
        byte_cnt <= 2'h0;
      end
      if (state == ST_LEN) begin
        len <= len_full;
        byte_cnt <= byte_cnt + 2'h1;
        rem <= len_full - LEN_FIELD_BYTES;
      end
      if ((in_body || state == ST_DRAIN) && !rem_zero) begin
        rem <= rem_dec;
      end
    end
  end

  // ****************************************
  // collection fields
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      hold <= 8'h00;
      phase <= 1'b0;
      idx_left <= 14'h0000;
      assign_byte <= 8'h00;
      DESC_KIND <= KIND_DECORR;
      DESC_SEG_INDEX <= 8'h00;
      DESC_XFORM <= XT_MATRIX;
      DESC_IN_COUNT <= 14'h0000;
      DESC_IN_WIDE <= 1'b0;
      DESC_OUT_COUNT <= 14'h0000;
      DESC_OUT_WIDE <= 1'b0;
    end else if (take && !rem_zero) begin
      unique case (state)
        ST_SEGIDX: begin
          DESC_SEG_INDEX <= IN_DATA;
          DESC_KIND <= kind;
          DESC_XFORM <= XT_MATRIX;
        end
        ST_XFORM: begin
          DESC_XFORM <= IN_DATA[XF_MATRIX_BIT] ? {1'b1, IN_DATA[0]} : XT_MATRIX;
        end
        ST_NCNT_HI, ST_MCNT_HI: hold <= IN_DATA;
        ST_NCNT_LO: begin
          DESC_IN_COUNT <= cnt_val;
          DESC_IN_WIDE <= (cnt_sel == SEL_WIDE);
          idx_left <= cnt_val;
          phase <= 1'b0;
        end
        ST_MCNT_LO: begin
          DESC_OUT_COUNT <= cnt_val;
          DESC_OUT_WIDE <= (cnt_sel == SEL_WIDE);
          idx_left <= cnt_val;
          phase <= 1'b0;
        end
        ST_NIDX, ST_MIDX: begin
          if (idx_needs_hi) begin
            hold <= IN_DATA;
            phase <= 1'b1;
          end else begin
            phase <= 1'b0;
            idx_left <= idx_left - 14'h0001;
          end
        end
        ST_ASSIGN: assign_byte <= IN_DATA;
        default: hold <= hold;
      endcase
    end
  end

  // ****************************************
  // index stream, in listed order
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      IDX_VALID <= 1'b0;
      IDX_DATA <= 16'h0000;
      IDX_OUTPUT <= 1'b0;
      IDX_KIND <= KIND_DECORR;
    end else if (idx_emit) begin
      IDX_VALID <= 1'b1;
      IDX_DATA <= idx_word;
      IDX_OUTPUT <= (state == ST_MIDX);
      IDX_KIND <= kind;
    end else if (IDX_READY) begin
      IDX_VALID <= 1'b0;
    end
  end

  // ****************************************
  // main and tile-part bookkeeping
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      SEG_DONE <= 1'b0;
      SEG_KIND <= KIND_DECORR;
      SEG_INDEX <= 8'h00;
      SEG_MAIN <= 1'b0;
      MAIN_DEFAULT <= 2'b00;
      TILE_OWN <= 2'b00;
      TILE_REF <= 2'b00;
      REF_INDEX_DECORR <= 8'h00;
      REF_INDEX_DEPEND <= 8'h00;
      main_cnt[0] <= 9'h000;
      main_cnt[1] <= 9'h000;
    end else begin
      SEG_DONE <= commit;
      // a new tile clears its own state; a commit in the same cycle wins
      if (TILE_START) begin
        TILE_OWN <= 2'b00;
        TILE_REF <= 2'b00;
      end
      if (commit) begin
        SEG_KIND <= kind;
        SEG_INDEX <= DESC_SEG_INDEX;
        SEG_MAIN <= seg_main;
        if (seg_main) begin
          main_cnt[kind] <= main_cnt[kind] + 9'h001;
          if (DESC_SEG_INDEX == 8'h00) begin
            MAIN_DEFAULT <= MAIN_DEFAULT | kind_hot;
          end
        end else if (seg_ref) begin
          TILE_REF <= (TILE_START ? 2'b00 : TILE_REF) | kind_hot;
          if (kind == KIND_DEPEND) begin
            REF_INDEX_DEPEND <= DESC_SEG_INDEX;
          end else begin
            REF_INDEX_DECORR <= DESC_SEG_INDEX;
          end
        end else begin
          TILE_OWN <= (TILE_START ? 2'b00 : TILE_OWN) | kind_hot;
        end
      end
    end
  end

  ccsp_seen_map #(
    .DEPTH(COMP_SPACE),
    .AW(COMP_AW)
  ) u_seen (
    .clock(CLOCK),
    .nrst(NRST),
    .clear_start(start_body),
    .busy(map_busy),
    .check_valid(check_out),
    .check_index(idx_word[COMP_AW-1:0]),
    .dup(map_dup)
  );

endmodule
`default_nettype wire

// ===== ccsp_parser_asserts.sv
// port checker for the collection segment parser
`timescale 1ns/1ps
`default_nettype none
module ccsp_parser_asserts #(
  parameter int COMP_SPACE = 16384,
  parameter int COMP_AW = 14
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic IN_VALID,
  input wire logic IN_READY,
  input wire logic IDX_VALID,
  input wire logic IDX_READY,
  input wire logic [15:0] IDX_DATA,
  input wire logic DESC_VALID,
  input wire logic DESC_READY,
  input wire logic DESC_KIND,
  input wire logic [7:0] DESC_SEG_INDEX,
  input wire logic [1:0] DESC_XFORM,
  input wire logic [13:0] DESC_IN_COUNT,
  input wire logic [13:0] DESC_OUT_COUNT,
  input wire logic [3:0] DESC_PRIMARY_INDEX,
  input wire logic DESC_PRIMARY_EN,
  input wire logic [3:0] DESC_SECONDARY_INDEX,
  input wire logic DESC_SECONDARY_EN,
  input wire logic SEG_DONE,
  input wire logic ERR_VALID
);
  // ****************************************
  // handshake and field checks
  // ****************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  a_desc_holds: assert property (DESC_VALID && !DESC_READY |=> DESC_VALID &&
    $stable(DESC_IN_COUNT) && $stable(DESC_SEG_INDEX)) else $error("descriptor dropped");
  a_idx_holds: assert property (IDX_VALID && !IDX_READY |=> IDX_VALID &&
    $stable(IDX_DATA)) else $error("index dropped");
  a_idx_stall: assert property (IDX_VALID && !IDX_READY |-> !IN_READY)
    else $error("bytes taken while index waits");
  a_idx_cause: assert property ($rose(IDX_VALID) |-> $past(IN_VALID) && $past(IN_READY))
    else $error("index without byte");
  a_prim_en: assert property (DESC_VALID |-> DESC_PRIMARY_EN == (DESC_PRIMARY_INDEX != 4'h0))
    else $error("primary enable wrong");
  a_sec_en: assert property (DESC_VALID |-> DESC_SECONDARY_EN == (DESC_SECONDARY_INDEX != 4'h0))
    else $error("secondary enable wrong");
  a_dep_square: assert property (DESC_VALID && DESC_KIND |-> DESC_IN_COUNT == DESC_OUT_COUNT)
    else $error("dependency not square");
  a_xform_legal: assert property (DESC_VALID |-> DESC_XFORM != 2'h1 &&
    (!DESC_KIND || DESC_XFORM == 2'h0)) else $error("bad transform type");
  a_desc_stall: assert property (DESC_VALID |-> !IN_READY)
    else $error("bytes taken during descriptor");
  a_done_excl: assert property (ERR_VALID |-> !SEG_DONE)
    else $error("error and done together");
endmodule
bind ccsp_parser ccsp_parser_asserts #(.COMP_SPACE(COMP_SPACE), .COMP_AW(COMP_AW)) u_chk (
  .CLOCK(CLOCK), .NRST(NRST), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
  .IDX_VALID(IDX_VALID), .IDX_READY(IDX_READY), .IDX_DATA(IDX_DATA),
  .DESC_VALID(DESC_VALID), .DESC_READY(DESC_READY), .DESC_KIND(DESC_KIND),
  .DESC_SEG_INDEX(DESC_SEG_INDEX), .DESC_XFORM(DESC_XFORM), .DESC_IN_COUNT(DESC_IN_COUNT),
  .DESC_OUT_COUNT(DESC_OUT_COUNT), .DESC_PRIMARY_INDEX(DESC_PRIMARY_INDEX),
  .DESC_PRIMARY_EN(DESC_PRIMARY_EN), .DESC_SECONDARY_INDEX(DESC_SECONDARY_INDEX),
  .DESC_SECONDARY_EN(DESC_SECONDARY_EN), .SEG_DONE(SEG_DONE), .ERR_VALID(ERR_VALID));
`default_nettype wire

// ===== ccsp_sink_model.sv
// transform stage model taking descriptors and indices
`timescale 1ns/1ps
`default_nettype none
module ccsp_sink_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic slow,
  output logic desc_ready,
  output logic idx_ready
);
  // ****************************************
  // ready pacing, stalls every other cycle when slow
  // ****************************************
  logic phase;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase <= 1'b0;
    end else begin
      phase <= !phase;
    end
  end
  assign desc_ready = !slow || phase;
  assign idx_ready = !slow || !phase;
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the collection segment parser
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ccsp_pkg::*;
  // ****************************************
  // stimulus, capture and checks
  // ****************************************
  logic CLOCK = 1'b0, NRST = 1'b0, IN_VALID = 1'b0, IN_MAIN_HDR = 1'b1;
  logic IN_FIRST_TILE_PART = 1'b0, TILE_START = 1'b0, slow = 1'b1;
  logic [7:0] IN_DATA = 8'h00;
  logic IN_READY, IDX_VALID, IDX_READY, IDX_OUTPUT, IDX_KIND, DESC_VALID, DESC_READY;
  logic DESC_KIND, DESC_IN_WIDE, DESC_OUT_WIDE, DESC_PRIMARY_EN, DESC_SECONDARY_EN;
  logic DESC_TILE_FIRST, SEG_DONE, SEG_KIND, SEG_MAIN, ERR_VALID;
  logic [15:0] IDX_DATA;
  logic [7:0] DESC_SEG_INDEX, SEG_INDEX, REF_INDEX_DECORR, REF_INDEX_DEPEND;
  logic [1:0] DESC_XFORM, MAIN_DEFAULT, TILE_OWN, TILE_REF;
  logic [13:0] DESC_IN_COUNT, DESC_OUT_COUNT;
  logic [3:0] DESC_PRIMARY_INDEX, DESC_SECONDARY_INDEX;
  logic [2:0] ERR_CODE;
  logic [51:0] dq[$];
  logic [17:0] iq[$];
  int fails = 0, checks = 0, ev_n = 0;
  always #2.5 CLOCK = ~CLOCK;
  ccsp_parser dut (.CLOCK(CLOCK), .NRST(NRST), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
    .IN_READY(IN_READY), .IN_MAIN_HDR(IN_MAIN_HDR), .IN_FIRST_TILE_PART(IN_FIRST_TILE_PART),
    .TILE_START(TILE_START), .IDX_VALID(IDX_VALID), .IDX_READY(IDX_READY),
    .IDX_DATA(IDX_DATA), .IDX_OUTPUT(IDX_OUTPUT), .IDX_KIND(IDX_KIND),
    .DESC_VALID(DESC_VALID), .DESC_READY(DESC_READY), .DESC_KIND(DESC_KIND),
    .DESC_SEG_INDEX(DESC_SEG_INDEX), .DESC_XFORM(DESC_XFORM), .DESC_IN_COUNT(DESC_IN_COUNT),
    .DESC_IN_WIDE(DESC_IN_WIDE), .DESC_OUT_COUNT(DESC_OUT_COUNT),
    .DESC_OUT_WIDE(DESC_OUT_WIDE), .DESC_PRIMARY_INDEX(DESC_PRIMARY_INDEX),
    .DESC_PRIMARY_EN(DESC_PRIMARY_EN), .DESC_SECONDARY_INDEX(DESC_SECONDARY_INDEX),
    .DESC_SECONDARY_EN(DESC_SECONDARY_EN), .DESC_TILE_FIRST(DESC_TILE_FIRST),
    .SEG_DONE(SEG_DONE), .SEG_KIND(SEG_KIND), .SEG_INDEX(SEG_INDEX), .SEG_MAIN(SEG_MAIN),
    .ERR_VALID(ERR_VALID), .ERR_CODE(ERR_CODE), .MAIN_DEFAULT(MAIN_DEFAULT),
    .TILE_OWN(TILE_OWN), .TILE_REF(TILE_REF), .REF_INDEX_DECORR(REF_INDEX_DECORR),
    .REF_INDEX_DEPEND(REF_INDEX_DEPEND));
  ccsp_sink_model u_sink (.clock(CLOCK), .nrst(NRST), .slow(slow),
    .desc_ready(DESC_READY), .idx_ready(IDX_READY));
  always @(posedge CLOCK) begin
    if (DESC_VALID && DESC_READY) begin
      dq.push_back({DESC_KIND, DESC_SEG_INDEX, DESC_XFORM, DESC_IN_COUNT, DESC_IN_WIDE,
        DESC_OUT_COUNT, DESC_OUT_WIDE, DESC_PRIMARY_INDEX, DESC_PRIMARY_EN,
        DESC_SECONDARY_INDEX, DESC_SECONDARY_EN, DESC_TILE_FIRST});
    end
    if (IDX_VALID && IDX_READY) begin
      iq.push_back({IDX_KIND, IDX_OUTPUT, IDX_DATA});
    end
    if (SEG_DONE || ERR_VALID) begin
      ev_n <= ev_n + 1;
    end
  end
  task automatic summarize();
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic seg(input logic [7:0] b[$]);
    int n;
    @(posedge CLOCK);
    foreach (b[i]) begin
      IN_DATA <= b[i];
      IN_VALID <= 1'b1;
      n = 0;
      @(negedge CLOCK);
      while (!IN_READY && n < 20000) begin
        n++;
        @(negedge CLOCK);
      end
      if (n >= 20000) begin
        chk("byte taken", 64'h1, 64'h0);
        summarize();
      end
      @(posedge CLOCK);
    end
    IN_VALID <= 1'b0;
  endtask
  task automatic wait_ev(input int prev);
    int n;
    n = 0;
    while (ev_n <= prev && n < 40000) begin
      n++;
      @(negedge CLOCK);
    end
    chk("segment end", 64'h1, 64'(ev_n > prev));
    if (ev_n <= prev) begin
      summarize();
    end
    @(negedge CLOCK);
  endtask
  initial begin
    repeat (6) @(posedge CLOCK);
    NRST <= 1'b1;
    seg('{8'hff, 8'h75, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h03, 8'h00, 8'h02, 8'h01,
      8'h02, 8'h00, 8'h02, 8'h05, 8'h06, 8'h21});
    wait_ev(0);
    chk("decorr desc", {1'b0, 8'h00, 2'h3, 14'h0002, 1'b0, 14'h0002, 1'b0, 4'h1, 1'b1, 4'h2, 1'b1,
      1'b0}, dq.size() == 1 ? dq[0] : 52'h0);
    chk("decorr indices", {18'h00001, 18'h00002, 18'h10005}, {iq[0], iq[1], iq[2]});
    chk("decorr last index", 18'h10006, iq[3]);
    chk("main default", 2'b01, MAIN_DEFAULT);
    dq.delete();
    iq.delete();
    slow <= 1'b0;
    seg('{8'hff, 8'h78, 8'h00, 8'h00, 8'h00, 8'h0d, 8'h03, 8'h40, 8'h01, 8'h01, 8'h05,
      8'h00, 8'h01, 8'h07, 8'h30});
    wait_ev(1);
    chk("depend desc", {1'b1, 8'h03, 2'h0, 14'h0001, 1'b1, 14'h0001, 1'b0, 4'h0, 1'b0, 4'h3, 1'b1,
      1'b0}, dq.size() == 1 ? dq[0] : 52'h0);
    chk("depend indices", {18'h20105, 18'h30007}, {iq[0], iq[1]});
    chk("main seg", {1'b1, 1'b1, 8'h03}, {SEG_KIND, SEG_MAIN, SEG_INDEX});
    dq.delete();
    @(posedge CLOCK);
    IN_MAIN_HDR <= 1'b0;
    IN_FIRST_TILE_PART <= 1'b1;
    seg('{8'hff, 8'h78, 8'h00, 8'h00, 8'h00, 8'h05, 8'h03});
    wait_ev(2);
    chk("tile bind", {1'b0, 8'h03, 2'b10, 8'h03}, {SEG_MAIN, SEG_INDEX, TILE_REF,
      REF_INDEX_DEPEND});
    chk("tile no desc", 64'h0, 64'(dq.size()));
    chk("tile own", 10'h000, {TILE_OWN, REF_INDEX_DECORR});
    @(posedge CLOCK);
    TILE_START <= 1'b1;
    @(posedge CLOCK);
    TILE_START <= 1'b0;
    IN_MAIN_HDR <= 1'b1;
    IN_FIRST_TILE_PART <= 1'b0;
    @(negedge CLOCK);
    chk("tile clear", 4'h0, {TILE_REF, TILE_OWN});
    seg('{8'hff, 8'h78, 8'h00, 8'h00, 8'h00, 8'h0d, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00,
      8'h02, 8'h01, 8'h02, 8'ha0});
    wait_ev(3);
    chk("square error", ERR_SQUARE, ERR_CODE);
    chk("square no desc", 64'h0, 64'(dq.size()));
    @(posedge CLOCK);
    seg('{8'hff, 8'h78, 8'h00, 8'h00, 8'h00, 8'h04});
    wait_ev(4);
    chk("short length", ERR_LENGTH, ERR_CODE);
    summarize();
  end
endmodule
`default_nettype wire
